// file: inc/dvrf_pkg.sv
// Constants shared by the volume register file, the gain scaler and the clock watcher.
package dvrf_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam int CODE_W = 8;
  localparam int NUM_CH = 8;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 9;
  localparam int UPDATE_BIT = 8;
  localparam int NUM_CTRL = 6;

  localparam logic [ADDR_W-1:0] ADDR_LEFT1 = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_RIGHT1 = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_ZD = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_FORMAT = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_LEFT2 = 7'h04;
  localparam logic [ADDR_W-1:0] ADDR_RIGHT2 = 7'h05;
  localparam logic [ADDR_W-1:0] ADDR_LEFT3 = 7'h06;
  localparam logic [ADDR_W-1:0] ADDR_RIGHT3 = 7'h07;
  localparam logic [ADDR_W-1:0] ADDR_ALL_GAIN = 7'h08;
  localparam logic [ADDR_W-1:0] ADDR_EMPH_MUTE = 7'h09;
  localparam logic [ADDR_W-1:0] ADDR_IF_POWER = 7'h0a;
  localparam logic [ADDR_W-1:0] ADDR_MUTE_PIN = 7'h0c;
  localparam logic [ADDR_W-1:0] ADDR_LEFT4 = 7'h0d;
  localparam logic [ADDR_W-1:0] ADDR_RIGHT4 = 7'h0e;
  localparam logic [ADDR_W-1:0] ADDR_PAIR4 = 7'h0f;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 7'h1f;

  // Channel order: L1, R1, L2, R2, L3, R3, L4, R4.
  localparam logic [ADDR_W-1:0] CH_ADDR [NUM_CH] = '{ADDR_LEFT1, ADDR_RIGHT1, ADDR_LEFT2,
    ADDR_RIGHT2, ADDR_LEFT3, ADDR_RIGHT3, ADDR_LEFT4, ADDR_RIGHT4};
  localparam logic [ADDR_W-1:0] CTRL_ADDR [NUM_CTRL] = '{ADDR_PHASE_ZD, ADDR_FORMAT,
    ADDR_EMPH_MUTE, ADDR_IF_POWER, ADDR_MUTE_PIN, ADDR_PAIR4};

  localparam logic [CODE_W-1:0] GAIN_RST = 8'hff;
  localparam logic [CODE_W-1:0] MUTE_CODE = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_RST [NUM_CTRL] = '{9'h120, 9'h000, 9'h000, 9'h040,
    9'h000, 9'h000};

  localparam logic [1:0] SWRST_MCLK_PERIODS = 2'h2;

  localparam int CLK_PERIOD_NS = 8;
  localparam int MCLK_LOSS_NS = 1000;
  localparam int MCLK_LOSS_CYC = MCLK_LOSS_NS / CLK_PERIOD_NS;

  // Gain mantissas for 0.5 dB steps inside one 6 dB octave, unsigned Q1.15.
  localparam int MANT_W = 16;
  localparam int MANT_FRAC = 15;
  localparam logic [CODE_W-1:0] STEPS_PER_OCT = 8'h0c;
  localparam logic [MANT_W-1:0] MANT [12] = '{16'h8000, 16'h78d7, 16'h7215, 16'h6bb3,
    16'h65ad, 16'h5ffd, 16'h5a9e, 16'h558c, 16'h50c3, 16'h4c3f, 16'h47fb, 16'h43f4};

  typedef enum logic {
    ST_RUN    = 1'b0,
    ST_SRESET = 1'b1
  } dvrf_state_e;
endpackage

// file: verilog/dvrf_mclk_watch.sv
// Master clock presence watcher: edge pulse and clock-lost level.
`timescale 1ns/1ps
`default_nettype none
module dvrf_mclk_watch #(
  parameter int LOSS_CYC = dvrf_pkg::MCLK_LOSS_CYC
) (
  input  wire logic clk_sys,   // System clock.
  input  wire logic reset,     // Synchronous reset, active high.
  input  wire logic mclk_in,   // Sampled master clock level.
  output logic      mclk_rise, // One-cycle pulse on a master clock rising edge.
  output logic      mclk_lost  // High while the master clock has stopped.
);
  logic        mclk_q_ff;
  logic [15:0] idle_cnt_ff;
  logic        lost_ff;
  logic        toggled;
  logic        timed_out;

  assign toggled = mclk_in ^ mclk_q_ff;
  assign mclk_rise = mclk_in & ~mclk_q_ff;
  assign timed_out = idle_cnt_ff >= 16'(LOSS_CYC - 1);
  assign mclk_lost = lost_ff;

  // The counter saturates, so a long stop keeps the lost level up.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mclk_q_ff <= 1'b0;
      idle_cnt_ff <= 16'h0000;
      lost_ff <= 1'b0;
    end else begin
      mclk_q_ff <= mclk_in;
      if (toggled) begin
        idle_cnt_ff <= 16'h0000;
        lost_ff <= 1'b0;
      end else if (!timed_out) begin
        idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      end else begin
        lost_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/dvrf_gain_scale.sv
// Sample scaler that turns an attenuation code into a gain and applies it.
`timescale 1ns/1ps
`default_nettype none
module dvrf_gain_scale #(
  parameter int SMP_W = 24
) (
  input  wire logic                       clk_sys,   // System clock.
  input  wire logic                       reset,     // Synchronous reset, active high.
  input  wire logic [dvrf_pkg::CODE_W-1:0] code,     // Active attenuation code.
  input  wire logic [SMP_W-1:0]           smp_in,    // Signed input sample.
  input  wire logic [2:0]                 smp_chan,  // Channel of the input sample.
  input  wire logic                       smp_valid, // Input sample strobe.
  output logic      [SMP_W-1:0]           smp_out,   // Scaled sample, registered.
  output logic      [2:0]                 chan_out,  // Channel of the scaled sample.
  output logic                            valid_out  // Output strobe, registered.
);
  localparam int PROD_W = SMP_W + dvrf_pkg::MANT_W + 1;

  logic [dvrf_pkg::CODE_W-1:0] atten;
  logic [4:0]                  octave;
  logic [3:0]                  step;
  logic [dvrf_pkg::MANT_W-1:0] mant;
  logic signed [PROD_W-1:0]    prod;
  logic signed [PROD_W-1:0]    shifted;
  logic [SMP_W-1:0]            nxt_smp;

  // Each octave of 12 half-dB steps halves the gain; 6 dB stands for 6.02 dB.
  assign atten = dvrf_pkg::GAIN_RST - code;
  assign octave = 5'(atten / dvrf_pkg::STEPS_PER_OCT);
  assign step = 4'(atten % dvrf_pkg::STEPS_PER_OCT);
  assign mant = dvrf_pkg::MANT[step];
  assign prod = $signed(smp_in) * $signed({1'b0, mant});
  assign shifted = prod >>> (dvrf_pkg::MANT_FRAC + int'(octave));
  assign nxt_smp = (code == dvrf_pkg::MUTE_CODE) ? '0 : shifted[SMP_W-1:0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      smp_out <= '0;
      chan_out <= 3'h0;
      valid_out <= 1'b0;
    end else begin
      valid_out <= smp_valid;
      if (smp_valid) begin
        smp_out <= nxt_smp;
        chan_out <= smp_chan;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/dvrf_regs.sv
// Control register file and eight-channel digital volume for the audio DAC.
`timescale 1ns/1ps
`default_nettype none
module dvrf_regs #(
  parameter int SMP_W = 24,
  parameter int LOSS_CYC = dvrf_pkg::MCLK_LOSS_CYC
) (
  input  wire logic                          clk_sys,                // System clock.
  input  wire logic                          reset,                  // Synchronous reset.
  input  wire logic [dvrf_pkg::WORD_W-1:0]   ctl_word,               // Received control word.
  input  wire logic                          ctl_valid,              // Control word strobe.
  input  wire logic                          mclk_in,                // Master clock level.
  input  wire logic [SMP_W-1:0]              smp_in,                 // Signed input sample.
  input  wire logic [2:0]                    smp_chan,               // Input sample channel.
  input  wire logic                          smp_valid,              // Input sample strobe.
  output logic      [SMP_W-1:0]              smp_out,                // Scaled sample.
  output logic      [2:0]                    smp_out_chan,           // Scaled sample channel.
  output logic                               smp_out_valid,          // Scaled sample strobe.
  output logic      [dvrf_pkg::CODE_W-1:0]   left_one_atten_code,    // Active code L1.
  output logic      [dvrf_pkg::CODE_W-1:0]   right_one_atten_code,   // Active code R1.
  output logic      [dvrf_pkg::CODE_W-1:0]   left_two_atten_code,    // Active code L2.
  output logic      [dvrf_pkg::CODE_W-1:0]   right_two_atten_code,   // Active code R2.
  output logic      [dvrf_pkg::CODE_W-1:0]   left_three_atten_code,  // Active code L3.
  output logic      [dvrf_pkg::CODE_W-1:0]   right_three_atten_code, // Active code R3.
  output logic      [dvrf_pkg::CODE_W-1:0]   left_four_atten_code,   // Active code L4.
  output logic      [dvrf_pkg::CODE_W-1:0]   right_four_atten_code,  // Active code R4.
  output logic      [dvrf_pkg::CODE_W-1:0]   global_atten_code,      // Master register.
  output logic      [dvrf_pkg::DATA_W-1:0]   phase_zero_detect_ctrl, // Control register.
  output logic      [dvrf_pkg::DATA_W-1:0]   audio_format_ctrl,      // Control register.
  output logic      [dvrf_pkg::DATA_W-1:0]   emphasis_mute_ctrl,     // Control register.
  output logic      [dvrf_pkg::DATA_W-1:0]   interface_power_ctrl,   // Control register.
  output logic      [dvrf_pkg::DATA_W-1:0]   mute_pin_decode_ctrl,   // Control register.
  output logic      [dvrf_pkg::DATA_W-1:0]   fourth_pair_ctrl,       // Control register.
  output logic                               soft_reset_busy,        // Software reset state.
  output logic                               mclk_lost               // Master clock stopped.
);
  localparam int NCH = dvrf_pkg::NUM_CH;
  localparam int CW = dvrf_pkg::CODE_W;
  localparam int NCT = dvrf_pkg::NUM_CTRL;

  // Control word fields.
  logic [dvrf_pkg::ADDR_W-1:0] wr_addr;
  logic [dvrf_pkg::DATA_W-1:0] wr_data;
  logic [CW-1:0]               wr_code;
  logic                        wr_update;

  // Address decode.
  logic [NCH-1:0] hit_ch;
  logic [NCT-1:0] hit_ctrl;
  logic           hit_master;
  logic           hit_swrst;
  logic           gain_write;
  logic           apply_all;
  logic           gain_clear;

  // Volume and control register state.
  logic [CW-1:0]               pend_ff [NCH];
  logic [CW-1:0]               act_ff [NCH];
  logic [CW-1:0]               nxt_pend [NCH];
  logic [CW-1:0]               nxt_act [NCH];
  logic [CW-1:0]               master_ff;
  logic [CW-1:0]               nxt_master;
  logic [NCH*CW-1:0]           act_flat;
  logic [NCH*CW-1:0]           pend_flat;
  logic [dvrf_pkg::DATA_W-1:0] ctrl_ff [NCT];
  logic [dvrf_pkg::DATA_W-1:0] nxt_ctrl [NCT];

  // Software reset sequencing.
  dvrf_pkg::dvrf_state_e state_ff;
  dvrf_pkg::dvrf_state_e nxt_state;
  logic [1:0]            rst_cnt_ff;
  logic [1:0]            nxt_rst_cnt;
  logic                  mclk_rise;
  logic                  clk_lost;

  // Sample path.
  logic [CW-1:0] smp_code;

  assign wr_addr = ctl_word[dvrf_pkg::ADDR_MSB:dvrf_pkg::ADDR_LSB];
  assign wr_data = ctl_word[dvrf_pkg::DATA_W-1:0];
  assign wr_code = wr_data[CW-1:0];
  assign wr_update = wr_data[dvrf_pkg::UPDATE_BIT];

  assign hit_master = ctl_valid && (wr_addr == dvrf_pkg::ADDR_ALL_GAIN);
  assign hit_swrst = ctl_valid && (wr_addr == dvrf_pkg::ADDR_SOFT_RESET);
  assign gain_write = (|hit_ch) || hit_master;
  // The update bit is only decoded here and never stored.
  assign apply_all = gain_write && wr_update;
  // Volumes fall back to 0 dB while the master clock is absent.
  assign gain_clear = hit_swrst || clk_lost;
  assign nxt_master = hit_master ? wr_code : master_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign hit_ch[gi] = ctl_valid && (wr_addr == dvrf_pkg::CH_ADDR[gi]);
      // Master writes land in every channel latch as well as its own.
      assign nxt_pend[gi] = (hit_ch[gi] || hit_master) ? wr_code : pend_ff[gi];
      assign nxt_act[gi] = apply_all ? nxt_pend[gi] : act_ff[gi];
      assign act_flat[gi*CW +: CW] = act_ff[gi];
      assign pend_flat[gi*CW +: CW] = pend_ff[gi];
    end
    for (gi = 0; gi < NCT; gi++) begin : g_ctrl
      assign hit_ctrl[gi] = ctl_valid && (wr_addr == dvrf_pkg::CTRL_ADDR[gi]);
      assign nxt_ctrl[gi] = hit_ctrl[gi] ? wr_data : ctrl_ff[gi];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NCH; i++) begin
      if (reset || gain_clear) begin
        pend_ff[i] <= dvrf_pkg::GAIN_RST;
        act_ff[i] <= dvrf_pkg::GAIN_RST;
      end else begin
        pend_ff[i] <= nxt_pend[i];
        act_ff[i] <= nxt_act[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || gain_clear) begin
      master_ff <= dvrf_pkg::GAIN_RST;
    end else begin
      master_ff <= nxt_master;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NCT; i++) begin
      if (reset || hit_swrst) begin
        ctrl_ff[i] <= dvrf_pkg::CTRL_RST[i];
      end else begin
        ctrl_ff[i] <= nxt_ctrl[i];
      end
    end
  end

  // The reset state counts master clock rises; any other write ends it early.
  always_comb begin
    nxt_state = state_ff;
    nxt_rst_cnt = rst_cnt_ff;
    unique case (state_ff)
      dvrf_pkg::ST_RUN: begin
        if (hit_swrst) begin
          nxt_state = dvrf_pkg::ST_SRESET;
          nxt_rst_cnt = 2'h0;
        end
      end
      dvrf_pkg::ST_SRESET: begin
        if (hit_swrst) begin
          nxt_rst_cnt = 2'h0;
        end else if (ctl_valid) begin
          nxt_state = dvrf_pkg::ST_RUN;
        end else if (mclk_rise) begin
          if (rst_cnt_ff == dvrf_pkg::SWRST_MCLK_PERIODS - 2'h1) begin
            nxt_state = dvrf_pkg::ST_RUN;
          end else begin
            nxt_rst_cnt = rst_cnt_ff + 2'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= dvrf_pkg::ST_RUN;
      rst_cnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      rst_cnt_ff <= nxt_rst_cnt;
    end
  end

  dvrf_mclk_watch #(
    .LOSS_CYC (LOSS_CYC)
  ) u_mclk_watch (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .mclk_in   (mclk_in),
    .mclk_rise (mclk_rise),
    .mclk_lost (clk_lost)
  );

  assign smp_code = act_ff[smp_chan];

  dvrf_gain_scale #(
    .SMP_W (SMP_W)
  ) u_gain_scale (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .code      (smp_code),
    .smp_in    (smp_in),
    .smp_chan  (smp_chan),
    .smp_valid (smp_valid),
    .smp_out   (smp_out),
    .chan_out  (smp_out_chan),
    .valid_out (smp_out_valid)
  );

  assign left_one_atten_code = act_ff[0];
  assign right_one_atten_code = act_ff[1];
  assign left_two_atten_code = act_ff[2];
  assign right_two_atten_code = act_ff[3];
  assign left_three_atten_code = act_ff[4];
  assign right_three_atten_code = act_ff[5];
  assign left_four_atten_code = act_ff[6];
  assign right_four_atten_code = act_ff[7];
  assign global_atten_code = master_ff;
  assign phase_zero_detect_ctrl = ctrl_ff[0];
  assign audio_format_ctrl = ctrl_ff[1];
  assign emphasis_mute_ctrl = ctrl_ff[2];
  assign interface_power_ctrl = ctrl_ff[3];
  assign mute_pin_decode_ctrl = ctrl_ff[4];
  assign fourth_pair_ctrl = ctrl_ff[5];
  assign soft_reset_busy = (state_ff == dvrf_pkg::ST_SRESET);
  assign mclk_lost = clk_lost;

  // Checks.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  logic plain_gain_wr;
  logic upd_gain_wr;
  assign plain_gain_wr = gain_write && !wr_update && !clk_lost;
  assign upd_gain_wr = gain_write && wr_update && !clk_lost;

  sequence s_upd_write;
    upd_gain_wr;
  endsequence

  sequence s_plain_write;
    plain_gain_wr;
  endsequence

  sequence s_swrst_quiet;
    hit_swrst ##1 (!ctl_valid && !mclk_rise && !clk_lost) [*3];
  endsequence

  // A master clock rise that is not yet the last one of the reset state.
  sequence s_rise_counted;
    soft_reset_busy && !ctl_valid && mclk_rise
      && rst_cnt_ff < dvrf_pkg::SWRST_MCLK_PERIODS - 2'h1;
  endsequence

  // The master clock rise that completes the reset state.
  sequence s_last_rise;
    soft_reset_busy && !ctl_valid && mclk_rise
      && rst_cnt_ff == dvrf_pkg::SWRST_MCLK_PERIODS - 2'h1;
  endsequence

  default_value_a: assert property (hit_swrst |=>
      act_flat == {NCH{dvrf_pkg::GAIN_RST}} && master_ff == dvrf_pkg::GAIN_RST)
    else $error("Attenuation registers not at 0 dB after software reset.");

  pend_store_a: assert property ((hit_ch[3] && !clk_lost) |=>
      pend_ff[3] == $past(wr_code))
    else $error("Channel code not held in its latch.");

  addr_map_a: assert property ((ctl_valid && wr_addr == dvrf_pkg::ADDR_LEFT4 && wr_update
      && !clk_lost) |=> left_four_atten_code == $past(wr_code))
    else $error("Left four code not taken at its address.");

  latch_hold_a: assert property (s_plain_write |=> $stable(act_flat))
    else $error("Output attenuation changed on a write without update.");

  update_all_a: assert property (s_upd_write |=> act_flat == pend_flat)
    else $error("Pending codes not applied together on update.");

  no_sticky_upd_a: assert property (s_upd_write ##[1:2] s_plain_write |=> $stable(act_flat))
    else $error("Update bit acted on a later write.");

  master_all_a: assert property ((hit_master && wr_update && !clk_lost) |=>
      act_flat == {NCH{$past(wr_code)}} && master_ff == $past(wr_code))
    else $error("Master write did not reach every channel.");

  clk_loss_a: assert property (clk_lost |=> act_flat == {NCH{dvrf_pkg::GAIN_RST}})
    else $error("Volumes not at 0 dB while master clock is stopped.");

  ctrl_reset_a: assert property (hit_swrst |=>
      phase_zero_detect_ctrl == dvrf_pkg::CTRL_RST[0]
      && interface_power_ctrl == dvrf_pkg::CTRL_RST[3])
    else $error("Control registers not at default after software reset.");

  swrst_hold_a: assert property (s_swrst_quiet |-> soft_reset_busy)
    else $error("Software reset ended without master clock or write.");

  swrst_early_a: assert property ((soft_reset_busy && ctl_valid && !hit_swrst) |=>
      !soft_reset_busy)
    else $error("Software reset not ended by a new write.");

  mute_zero_a: assert property ((smp_valid && smp_code == dvrf_pkg::MUTE_CODE) |=>
      smp_out_valid && smp_out == '0)
    else $error("Muted channel produced a non-zero sample.");

  unity_gain_a: assert property ((smp_valid && smp_code == dvrf_pkg::GAIN_RST) |=>
      smp_out == $past(smp_in) && smp_out_chan == $past(smp_chan))
    else $error("Code FF did not pass the sample unchanged.");

  ctrl_write_a: assert property (hit_ctrl[1] |=>
      audio_format_ctrl == $past(wr_data))
    else $error("Format register not written at its address.");

  unmapped_ignore_a: assert property ((ctl_valid && !gain_write && !(|hit_ctrl)
      && !hit_swrst && !clk_lost) |=> $stable(pend_flat) && $stable(master_ff)
      && $stable(audio_format_ctrl))
    else $error("Write to an unmapped address changed a register.");

  pend_master_a: assert property ((hit_master && !wr_update && !clk_lost) |=>
      pend_flat == {NCH{$past(wr_code)}} && $stable(act_flat))
    else $error("Master write without update did not fill only the latches.");

  busy_enter_a: assert property (hit_swrst |=> soft_reset_busy)
    else $error("Software reset state not entered.");

  swrst_count_a: assert property (s_rise_counted |=>
      soft_reset_busy && rst_cnt_ff == $past(rst_cnt_ff) + 2'h1)
    else $error("Software reset ended before its second master clock period.");

  swrst_end_a: assert property (s_last_rise |=> !soft_reset_busy)
    else $error("Software reset outlasted two master clock periods.");

  chan_tag_a: assert property (smp_valid |=>
      smp_out_valid && smp_out_chan == $past(smp_chan))
    else $error("Scaled sample lost its strobe or channel.");

  octave_half_a: assert property ((smp_valid
      && smp_code == dvrf_pkg::GAIN_RST - dvrf_pkg::STEPS_PER_OCT) |=>
      $signed(smp_out) == ($signed($past(smp_in)) >>> 1))
    else $error("Twelve half-dB steps did not halve the sample.");
endmodule
`default_nettype wire

// file: sim/dvrf_host_model.sv
// Host controller model: sends control words and runs the master clock.
`timescale 1ns/1ps
`default_nettype none
module dvrf_host_model (
  input  wire logic                        clk_sys,   // System clock.
  output logic      [dvrf_pkg::WORD_W-1:0] ctl_word,  // Control word.
  output logic                             ctl_valid, // Word strobe.
  output logic                             mclk_in    // Master clock.
);
  logic       mclk_run = 1'b1;
  logic [1:0] div_ff   = 2'h0;
  initial begin
    ctl_word  = 16'h0000;
    ctl_valid = 1'b0;
    mclk_in   = 1'b0;
  end
  // A stopped master clock holds its last level.
  always @(negedge clk_sys) begin
    if (mclk_run) begin
      div_ff <= div_ff + 2'h1;
      if (div_ff == 2'h3) mclk_in <= ~mclk_in;
    end
  end
  task automatic write_reg(input logic [6:0] a, input logic u, input logic [7:0] d);
    @(negedge clk_sys);
    ctl_word  = {a, u, d};
    ctl_valid = 1'b1;
    @(negedge clk_sys);
    ctl_valid = 1'b0;
    ctl_word  = ~ctl_word;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the volume register file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic              clk_sys   = 1'b0;
  logic              reset     = 1'b1;
  logic [23:0]       smp_in    = 24'h00_0000;
  logic [2:0]        smp_chan  = 3'h0;
  logic              smp_valid = 1'b0;
  wire logic [15:0]  ctl_word;
  wire logic         ctl_valid;
  wire logic         mclk_in;
  wire logic [23:0]  so;
  wire logic [2:0]   so_ch;
  wire logic         so_v;
  wire logic [7:0]   act [8];
  wire logic [7:0]   glob;
  wire logic [8:0]   ctl [6];
  wire logic         busy;
  wire logic         lost;
  int                mismatches   = 0;
  int                total_checks = 0;
  int                cycles       = 0;
  logic [7:0]        ex [8];

  always #4 clk_sys = ~clk_sys;

  dvrf_host_model dvrf_host_model_i (.clk_sys(clk_sys), .ctl_word(ctl_word),
    .ctl_valid(ctl_valid), .mclk_in(mclk_in));
  dvrf_regs #(.SMP_W(24), .LOSS_CYC(20)) dvrf_regs_i (.clk_sys(clk_sys), .reset(reset),
    .ctl_word(ctl_word), .ctl_valid(ctl_valid), .mclk_in(mclk_in), .smp_in(smp_in),
    .smp_chan(smp_chan), .smp_valid(smp_valid), .smp_out(so), .smp_out_chan(so_ch),
    .smp_out_valid(so_v), .left_one_atten_code(act[0]), .right_one_atten_code(act[1]),
    .left_two_atten_code(act[2]), .right_two_atten_code(act[3]),
    .left_three_atten_code(act[4]), .right_three_atten_code(act[5]),
    .left_four_atten_code(act[6]), .right_four_atten_code(act[7]),
    .global_atten_code(glob), .phase_zero_detect_ctrl(ctl[0]), .audio_format_ctrl(ctl[1]),
    .emphasis_mute_ctrl(ctl[2]), .interface_power_ctrl(ctl[3]),
    .mute_pin_decode_ctrl(ctl[4]), .fourth_pair_ctrl(ctl[5]), .soft_reset_busy(busy),
    .mclk_lost(lost));

  task automatic tally(input string nm, input logic ok, input logic [23:0] e, g);
    total_checks++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_code(input string nm, input logic [7:0] e, g);
    tally(nm, e === g, {16'h0000, e}, {16'h0000, g});
  endtask
  task automatic chk_ctrl(input string nm, input logic [8:0] e, g);
    tally(nm, e === g, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic chk_flag(input string nm, input logic e, g);
    tally(nm, e === g, {23'h00_0000, e}, {23'h00_0000, g});
  endtask
  task automatic chk_smp(input string nm, input logic [23:0] e, g);
    tally(nm, e === g, e, g);
  endtask
  task automatic chk_all(input logic [7:0] gl);
    for (int i = 0; i < 8; i++) chk_code("active_code", ex[i], act[i]);
    chk_code("global_code", gl, glob);
  endtask
  task automatic fill(input logic [7:0] c);
    for (int i = 0; i < 8; i++) ex[i] = c;
  endtask
  task automatic wr(input logic [6:0] a, input logic u, input logic [7:0] d);
    dvrf_host_model_i.write_reg(a, u, d);
  endtask
  task automatic smp(input logic [2:0] ch, input logic [23:0] s, e);
    @(negedge clk_sys);
    smp_in    = s;
    smp_chan  = ch;
    smp_valid = 1'b1;
    @(negedge clk_sys);
    smp_valid = 1'b0;
    chk_flag("smp_out_valid", 1'b1, so_v);
    chk_smp("smp_out", e, so);
    chk_smp("smp_out_chan", {21'h00_0000, ch}, {21'h00_0000, so_ch});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    fill(8'hff);
    chk_all(8'hff);
    for (int i = 0; i < 6; i++) chk_ctrl("ctrl_reg", dvrf_pkg::CTRL_RST[i], ctl[i]);
    for (int i = 0; i < 8; i++) wr(dvrf_pkg::CH_ADDR[i], 1'b0, 8'h10 + 8'(i));
    chk_all(8'hff);
    wr(dvrf_pkg::ADDR_LEFT1, 1'b1, 8'h3c);
    for (int i = 0; i < 8; i++) ex[i] = 8'h10 + 8'(i);
    ex[0] = 8'h3c;
    chk_all(8'hff);
    wr(dvrf_pkg::ADDR_RIGHT1, 1'b0, 8'h55);
    chk_all(8'hff);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b0, 8'h80);
    chk_all(8'h80);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b1, 8'h90);
    fill(8'h90);
    chk_all(8'h90);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b1, 8'hff);
    smp(3'h0, 24'h10_0000, 24'h10_0000);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b1, 8'hfe);
    smp(3'h3, 24'h10_0000, 24'h0f_1ae0);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b1, 8'hf3);
    smp(3'h5, 24'h10_0000, 24'h08_0000);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b1, 8'he7);
    smp(3'h6, 24'h10_0000, 24'h04_0000);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b1, 8'h01);
    smp(3'h7, 24'h10_0000, 24'h00_0000);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b1, 8'h00);
    smp(3'h2, 24'h7f_ffff, 24'h00_0000);
    wr(dvrf_pkg::ADDR_FORMAT, 1'b0, 8'ha5);
    chk_ctrl("format", 9'h0a5, ctl[1]);
    wr(dvrf_pkg::ADDR_SOFT_RESET, 1'b0, 8'h00);
    chk_flag("soft_reset_busy", 1'b1, busy);
    chk_ctrl("format", 9'h000, ctl[1]);
    fill(8'hff);
    chk_all(8'hff);
    wr(dvrf_pkg::ADDR_FORMAT, 1'b0, 8'h33);
    chk_flag("soft_reset_busy", 1'b0, busy);
    chk_ctrl("format", 9'h033, ctl[1]);
    wr(dvrf_pkg::ADDR_SOFT_RESET, 1'b0, 8'h00);
    chk_flag("soft_reset_busy", 1'b1, busy);
    repeat (24) @(negedge clk_sys);
    chk_flag("soft_reset_busy", 1'b0, busy);
    wr(7'h0b, 1'b0, 8'hff);
    for (int i = 0; i < 6; i++) chk_ctrl("ctrl_reg", dvrf_pkg::CTRL_RST[i], ctl[i]);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b1, 8'h20);
    dvrf_host_model_i.mclk_run = 1'b0;
    repeat (40) @(negedge clk_sys);
    chk_flag("mclk_lost", 1'b1, lost);
    for (int i = 0; i < 8; i++) chk_code("active_code", 8'hff, act[i]);
    dvrf_host_model_i.mclk_run = 1'b1;
    repeat (12) @(negedge clk_sys);
    chk_flag("mclk_lost", 1'b0, lost);
    wr(dvrf_pkg::ADDR_ALL_GAIN, 1'b1, 8'h44);
    fill(8'h44);
    chk_all(8'h44);
    wrap_up();
  end
endmodule
`default_nettype wire
